// >>> hw/cwa_aligner.sv
`timescale 1ns/10ps
module cwa_aligner
	import cwa_pkg::*;
#(
	parameter int DATA_W   = CWA_DATA_W,
	parameter int QUAL_CNT = CWA_QUAL_CNT
) (
	// Clock and reset.
	input  wire logic              REF_CLK_I,
	input  wire logic              SYS_RST_I,
	// Configuration.
	input  wire cwa_pkg::cwa_mode_t MODE_I,
	input  wire cwa_pkg::cwa_len_t  PAT_LEN_I,
	input  wire logic [31:0]       PATTERN_I,
	input  wire logic              COMPL_EN_I,
	// Parallel words from the deserializer.
	input  wire logic [DATA_W-1:0] RX_DATA_I,
	input  wire logic              RX_VALID_I,
	output logic                   RX_READY_O,
	// Aligned words toward the fabric.
	output logic [DATA_W-1:0]      DATA_O,
	output logic                   DATA_VALID_O,
	input  wire logic              DATA_READY_I,
	// Status.
	output logic                   PAT_DET_O,
	output logic                   SYNC_STATUS_O
);
	import cwa_pkg::*;

	localparam int OFS_W = $clog2(DATA_W);

	typedef struct packed {
		logic [DATA_W-1:0]     prev;
		logic [OFS_W-1:0]      ofs;
		logic                  locked;
		logic                  cand;
		logic [CWA_QUAL_W-1:0] qual;
	} cwa_st_t;

	cwa_st_t               st_r;
	cwa_st_t               st_nxt;
	logic [2*DATA_W-1:0]   win;
	logic [31:0]           pat;
	logic [31:0]           mask;
	logic                  allow_c;
	logic [DATA_W-1:0]     match_vec;
	logic                  hit_any;
	logic [OFS_W-1:0]      hit_ofs;
	logic                  acc;
	logic                  det;
	logic [31:0]           seg;
	logic [2*DATA_W-1:0]   shifted;

	cwa_buf_if #(.WIDTH(DATA_W + 1)) obuf ();

	cwa_buf #(
		.WIDTH (DATA_W + 1)
	) u_obuf (
		.clk_i (REF_CLK_I),
		.rst_i (SYS_RST_I),
		.bus   (obuf.buf_side)
	);

	// Pattern, length and match sense per mode; the standard mode ignores the programmed pattern.
	always_comb begin
		if (MODE_I == CWA_MODE_STD) begin
			pat     = CWA_COMMA;
			mask    = cwa_len_mask(CWA_LEN10);
			allow_c = 1'b1; // Either running disparity of the comma is accepted.
		end else begin
			pat     = PATTERN_I;
			mask    = cwa_len_mask(PAT_LEN_I);
			allow_c = COMPL_EN_I;
		end
	end

	// Older word sits in the low half, so lower positions were received earlier.
	assign win = {RX_DATA_I, st_r.prev};

	// Match at every position, then keep the lowest; the loop runs downward so the lowest writes last.
	always_comb begin
		seg       = '0;
		match_vec = '0;
		hit_any   = 1'b0;
		hit_ofs   = '0;
		for (int i = 0; i < DATA_W; i++) begin
			seg          = 32'(win >> i);
			match_vec[i] = (((seg ^ pat) & mask) == '0) || (allow_c && (((seg ^ ~pat) & mask) == '0));
		end
		for (int i = DATA_W - 1; i >= 0; i--) begin
			if (match_vec[i]) begin
				hit_any = 1'b1;
				hit_ofs = OFS_W'(i);
			end
		end
	end

	assign acc = RX_VALID_I && obuf.push_ready;

	// Search and lock. A word is consumed only when the buffer can take it, so a stall loses nothing.
	always_comb begin
		st_nxt = st_r;
		if (acc) begin
			st_nxt.prev = RX_DATA_I;
			if (!st_r.locked && hit_any) begin
				if (MODE_I != CWA_MODE_STD) begin
					st_nxt.locked = 1'b1;
					st_nxt.ofs    = hit_ofs;
				end else if (st_r.cand && hit_ofs == st_r.ofs) begin
					// Repeat comma at the same boundary counts toward acquisition.
					st_nxt.qual   = st_r.qual + CWA_QUAL_W'(1);
					st_nxt.locked = st_nxt.qual >= CWA_QUAL_W'(QUAL_CNT);
				end else begin
					// A comma elsewhere restarts qualification at the new boundary.
					st_nxt.cand   = 1'b1;
					st_nxt.ofs    = hit_ofs;
					st_nxt.qual   = CWA_QUAL_W'(1);
					st_nxt.locked = QUAL_CNT == 1;
				end
			end
		end
	end

	// The word leaving is shifted by the boundary in force after this word, so a fresh lock aligns it too.
	always_comb begin
		shifted = win >> st_nxt.ofs;
		det     = st_nxt.locked && match_vec[st_nxt.ofs];
	end

	assign obuf.push_valid = acc;
	assign obuf.push_data  = {det, shifted[DATA_W-1:0]};
	assign obuf.pop_ready  = DATA_READY_I;

	// State register; reset drops lock and restarts an unaligned search.
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I) begin
			st_r <= '0;
		end else if (!st_r.locked) begin
			st_r <= st_nxt;
		end else begin
			st_r.prev <= st_nxt.prev;
		end
	end

	// Outputs; the buffer regs drive data and ready, the lock flop drives sync.
	assign RX_READY_O    = obuf.push_ready;
	assign DATA_O        = obuf.pop_data[DATA_W-1:0];
	assign PAT_DET_O     = obuf.pop_data[DATA_W];
	assign DATA_VALID_O  = obuf.pop_valid;
	assign SYNC_STATUS_O = st_r.locked;

	if (DATA_W < CWA_PAT_MAX || QUAL_CNT < 1 || QUAL_CNT >= (1 << CWA_QUAL_W)) begin : g_chk
		$error("DATA_W must be at least 32 and QUAL_CNT within 1..15.");
	end

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_first_hit;
		acc && !st_r.locked && hit_any;
	endsequence
	sequence s_std_hit;
		s_first_hit ##0 (MODE_I == CWA_MODE_STD);
	endsequence

	lock_hold_a: assert property (st_r.locked |=> (st_r.locked && $stable(st_r.ofs))) else $error("Boundary moved.");
	reset_clear_a: assert property (@(posedge REF_CLK_I) disable iff (1'b0) SYS_RST_I |=> (!SYNC_STATUS_O && st_r.ofs == '0 && !DATA_VALID_O)) else $error("Reset left state.");
	sync_cause_a: assert property ($rose(SYNC_STATUS_O) |-> $past(acc && hit_any)) else $error("Sync rose without a match.");
	lowest_pick_a: assert property (hit_any |-> (match_vec[hit_ofs] && (match_vec & ((DATA_W'(1) << hit_ofs) - DATA_W'(1))) == '0)) else $error("Not the lowest match.");
	custom_lock_a: assert property ((s_first_hit ##0 (MODE_I != CWA_MODE_STD)) |=> (st_r.locked && st_r.ofs == $past(hit_ofs))) else $error("Custom lock missed.");
	aligned_low_a: assert property ((acc && det) |-> ((((obuf.push_data[31:0] ^ pat) & mask) == '0) || (allow_c && (((obuf.push_data[31:0] ^ ~pat) & mask) == '0)))) else $error("Pattern not in low bits.");
	exact_only_a: assert property ((s_first_hit ##0 (MODE_I != CWA_MODE_STD && !COMPL_EN_I)) |-> (((32'(win >> hit_ofs) ^ PATTERN_I) & mask) == '0)) else $error("Complement taken in exact mode.");
	std_qual_a: assert property (($rose(st_r.locked) && $past(MODE_I) == CWA_MODE_STD) |-> $past(st_r.qual) == CWA_QUAL_W'(QUAL_CNT - 1) || QUAL_CNT == 1) else $error("Comma lock without qualification.");
	std_wait_a: assert property ((s_std_hit ##0 !st_r.cand) |=> (!st_r.locked || QUAL_CNT == 1) && st_r.qual == CWA_QUAL_W'(1)) else $error("Comma qualification skipped.");

endmodule // cwa_aligner

// >>> hw/cwa_buf.sv
`timescale 1ns/10ps
module cwa_buf
	import cwa_pkg::*;
#(
	parameter int WIDTH = 33
) (
	// Clock and reset.
	input wire logic  clk_i,
	input wire logic  rst_i,
	// Buffer ports.
	cwa_buf_if.buf_side bus
);
	import cwa_pkg::*;

	localparam int CNT_W = $clog2(CWA_BUF_DEPTH + 1);

	typedef struct packed {
		logic [CWA_BUF_DEPTH-1:0][WIDTH-1:0] ent;
		logic [CNT_W-1:0]                    cnt;
		logic                                rdy;
		logic                                vld;
	} cwa_buf_st_t;

	cwa_buf_st_t st_r;
	cwa_buf_st_t st_nxt;
	logic        do_push;
	logic        do_pop;

	// Entry 0 is the head so the output data leaves straight from a flop.
	always_comb begin
		st_nxt  = st_r;
		do_push = bus.push_valid && st_r.rdy;
		do_pop  = st_r.vld && bus.pop_ready;
		if (do_pop) begin
			// The vacated tail is cleared so an empty head always reads as zero, flags included.
			st_nxt.ent[0] = st_r.ent[1];
			st_nxt.ent[1] = '0;
			st_nxt.cnt    = st_r.cnt - CNT_W'(1);
		end
		if (do_push) begin
			st_nxt.ent[st_nxt.cnt[0]] = bus.push_data;
			st_nxt.cnt                = st_nxt.cnt + CNT_W'(1);
		end
		// Ready is a flop so a stalled reader holds the writer off a cycle early enough.
		st_nxt.rdy = st_nxt.cnt < CNT_W'(CWA_BUF_DEPTH);
		st_nxt.vld = st_nxt.cnt != '0;
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign bus.push_ready = st_r.rdy;
	assign bus.pop_valid  = st_r.vld;
	assign bus.pop_data   = st_r.ent[0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	buf_full_hold_a: assert property ((st_r.cnt == CNT_W'(CWA_BUF_DEPTH) && !bus.pop_ready) |=>
		(st_r.cnt == CNT_W'(CWA_BUF_DEPTH) && $stable(st_r.ent))) else $error("Full buffer changed while stalled.");
	buf_head_keep_a: assert property ((st_r.vld && !bus.pop_ready) |=> (st_r.vld && $stable(bus.pop_data)))
		else $error("Head word lost while stalled.");

	if (CWA_BUF_DEPTH != 2) begin : g_chk
		$error("Buffer logic serves exactly two entries.");
	end

endmodule // cwa_buf

// >>> hw/cwa_buf_if.sv
`timescale 1ns/10ps
interface cwa_buf_if #(parameter int WIDTH = 33);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;

	modport buf_side (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
	modport user     (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface

// >>> hw/cwa_pkg.sv
package cwa_pkg;

	// Widest pattern the detector can compare, and the default parallel width.
	localparam int          CWA_PAT_MAX  = 32;
	localparam int          CWA_DATA_W   = 32;
	// Matches at one boundary needed before lock in the standard-protocol mode.
	localparam int          CWA_QUAL_CNT = 3;
	localparam int          CWA_QUAL_W   = 4;
	// Entries in the output buffer.
	localparam int          CWA_BUF_DEPTH = 2;
	// Comma code in transmission order, first bit in bit 0.
	localparam logic [31:0] CWA_COMMA    = 32'h0000017c;

	// Pattern length selection.
	typedef enum logic [2:0] {
		CWA_LEN7  = 3'b000,
		CWA_LEN8  = 3'b001,
		CWA_LEN10 = 3'b010,
		CWA_LEN16 = 3'b011,
		CWA_LEN20 = 3'b100,
		CWA_LEN32 = 3'b101,
		CWA_LEN23 = 3'b110
	} cwa_len_t;

	// Alignment mode.
	typedef enum logic [1:0] {
		CWA_MODE_CUSTOM = 2'b00,
		CWA_MODE_STD    = 2'b01,
		CWA_MODE_PRBS   = 2'b10
	} cwa_mode_t;

	// Compare mask for a pattern length; unknown codes compare nothing.
	function automatic logic [31:0] cwa_len_mask(input cwa_len_t len);
		case (len)
			CWA_LEN7:  cwa_len_mask = 32'h0000007f;
			CWA_LEN8:  cwa_len_mask = 32'h000000ff;
			CWA_LEN10: cwa_len_mask = 32'h000003ff;
			CWA_LEN16: cwa_len_mask = 32'h0000ffff;
			CWA_LEN20: cwa_len_mask = 32'h000fffff;
			CWA_LEN32: cwa_len_mask = 32'hffffffff;
			CWA_LEN23: cwa_len_mask = 32'h007fffff;
			default:   cwa_len_mask = 32'h00000000;
		endcase
	endfunction

endpackage

// >>> testbench/cwa_src_model.sv
`timescale 1ns/10ps
// Deserializer stand-in: holds each queued word until the aligner takes it.
module cwa_src_model (
	// Clock.
	input  wire logic   clk_i,
	// Word handshake.
	input  wire logic   ready_i,
	output logic        valid_o,
	output logic [31:0] data_o
);
	logic [31:0] word_q[$];

	// Idle data flips every cycle, so a stale word never looks held.
	initial begin
		valid_o = 1'b0;
		data_o  = 32'h00000000;
	end

	// Pop at the taking edge, then show the next word just after it.
	always @(posedge clk_i) begin
		if (valid_o && ready_i && word_q.size() > 0) begin
			void'(word_q.pop_front());
		end
		#1;
		valid_o = (word_q.size() > 0);
		data_o  = valid_o ? word_q[0] : ~data_o;
	end
endmodule // cwa_src_model

// >>> testbench/tb_comma_word_aligner.sv
`timescale 1ns/10ps
// Bench plays the fabric; the source model plays the deserializer.
module tb_comma_word_aligner;
	import cwa_pkg::*;

	logic        clk, rst, compl_en, rx_valid, rx_ready;
	logic        data_valid, data_ready, pat_det, sync;
	logic [31:0] pattern, rx_data, data_out;
	cwa_mode_t   mode;
	cwa_len_t    pat_len;
	int          errors, comparisons;
	logic [31:0] got_d[$];
	logic        got_p[$];

	// Free-running 250 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	cwa_aligner uut (.REF_CLK_I(clk), .SYS_RST_I(rst), .MODE_I(mode), .PAT_LEN_I(pat_len),
		.PATTERN_I(pattern), .COMPL_EN_I(compl_en), .RX_DATA_I(rx_data), .RX_VALID_I(rx_valid),
		.RX_READY_O(rx_ready), .DATA_O(data_out), .DATA_VALID_O(data_valid),
		.DATA_READY_I(data_ready), .PAT_DET_O(pat_det), .SYNC_STATUS_O(sync));

	cwa_src_model src (.clk_i(clk), .ready_i(rx_ready), .valid_o(rx_valid), .data_o(rx_data));

	// Record every word the fabric takes, with its detect flag.
	always @(posedge clk) begin
		if (data_valid === 1'b1 && data_ready === 1'b1) begin
			got_d.push_back(data_out);
			got_p.push_back(pat_det);
		end
	end

	// Word comparison; flags reuse it zero-extended.
	task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic check_bit(input logic exp, input logic got);
		check_word({31'h0, exp}, {31'h0, got});
	endtask

	// Configuration changes only while reset is held.
	task automatic do_reset(input cwa_mode_t m, input cwa_len_t l, input logic [31:0] p, input logic c);
		@(posedge clk);
		#1;
		rst      = 1'b1;
		mode     = m;
		pat_len  = l;
		pattern  = p;
		compl_en = c;
		src.word_q.delete();
		repeat (3) @(posedge clk);
		#1;
		check_bit(1'b0, sync);
		check_bit(1'b0, pat_det);
		check_bit(1'b0, data_valid);
		rst = 1'b0;
		got_d.delete();
		got_p.delete();
	endtask

	// Bounded wait for n taken words.
	task automatic drain(input int n);
		int k;
		k = 0;
		while (got_d.size() < n && k < 200) begin
			@(posedge clk);
			k++;
		end
		#1;
		check_word(32'(n), 32'(got_d.size()));
	endtask

	task automatic send2(input logic [63:0] win);
		src.word_q.push_back(win[31:0]);
		src.word_q.push_back(win[63:32]);
	endtask

	// Two matches: the first one locks, then the boundary holds through a stall and the later match.
	task automatic t_lowest_lock();
		logic [31:0] w[6];
		w = '{32'h50000000, 32'h000a500a, 32'h12345670, 32'h000000a5, 32'hfedcba98, 32'h0f0f0f0f};
		do_reset(CWA_MODE_CUSTOM, CWA_LEN8, 32'h000000a5, 1'b0);
		data_ready = 1'b0;
		foreach (w[i]) src.word_q.push_back(w[i]);
		repeat (12) @(posedge clk);
		#1;
		check_bit(1'b0, rx_ready);
		data_ready = 1'b1;
		drain(6);
		check_bit(1'b0, data_valid);
		check_word(32'h00a500a5, got_d[1]);
		check_bit(1'b1, got_p[1]);
		check_bit(1'b1, sync);
		for (int i = 2; i < 6; i++) begin
			check_word({w[i][27:0], w[i-1][31:28]}, got_d[i]);
			check_bit(1'b0, got_p[i]);
		end
	endtask

	// The complement must not lock when only the exact pattern is allowed.
	task automatic t_exact_only();
		do_reset(CWA_MODE_CUSTOM, CWA_LEN8, 32'h0000005a, 1'b0);
		send2(64'ha5 << 28);
		send2(64'h0);
		drain(4);
		repeat (2) @(posedge clk);
		#1;
		check_bit(1'b0, sync);
		check_bit(1'b0, got_p[1]);
	endtask

	// Every length once, exact and complement in turn, match straddling two words.
	task automatic t_lengths();
		cwa_len_t    lens[7];
		int          wid[7];
		logic [31:0] m, s;
		lens = '{CWA_LEN7, CWA_LEN8, CWA_LEN10, CWA_LEN16, CWA_LEN20, CWA_LEN32, CWA_LEN23};
		wid  = '{7, 8, 10, 16, 20, 32, 23};
		for (int i = 0; i < 7; i++) begin
			m = 32'hffffffff >> (32 - wid[i]);
			s = (i % 2 == 1) ? (32'haaaaaaaa & m) : (32'h55555555 & m);
			do_reset((wid[i] == 7 || wid[i] == 23) ? CWA_MODE_PRBS : CWA_MODE_CUSTOM,
				lens[i], 32'h55555555 & m, i % 2 == 1);
			send2({32'h0, s} << 28);
			drain(2);
			check_word(s, got_d[1]);
			check_bit(1'b1, got_p[1]);
		end
	endtask

	// Standard mode locks only on the third match at one boundary.
	task automatic t_std_qual();
		do_reset(CWA_MODE_STD, CWA_LEN32, 32'h00000000, 1'b0);
		repeat (3) src.word_q.push_back(32'hc0000017);
		drain(3);
		repeat (3) @(posedge clk);
		#1;
		check_bit(1'b0, sync);
		src.word_q.push_back(32'hc0000017);
		drain(4);
		repeat (2) @(posedge clk);
		#1;
		check_bit(1'b1, sync);
		check_word(CWA_COMMA, got_d[3]);
	endtask

	task automatic final_report();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence; each reset after a lock also shows the lock cleared.
	initial begin
		rst         = 1'b1;
		data_ready  = 1'b1;
		mode        = CWA_MODE_CUSTOM;
		pat_len     = CWA_LEN8;
		pattern     = 32'h00000000;
		compl_en    = 1'b0;
		errors      = 0;
		comparisons = 0;
		t_lowest_lock();
		t_exact_only();
		t_lengths();
		t_std_qual();
		final_report();
	end

	// Watchdog: the run needs well under a thousand cycles.
	initial begin
		#40000;
		errors++;
		final_report();
	end
endmodule // tb_comma_word_aligner
